// File: hdl/urx_rxbuf.sv
// two-entry receive buffer holding character plus per-frame status
// assumes the owner never pushes while full and never pops while empty
`timescale 1ns/1ps
module urx_rxbuf #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // buffer port
  urx_buf_if.buffer bif
);
  import urx_pkg::*;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [W-1:0] mem_q [2];  // two entries
  logic         wp_q;       // write slot
  logic         rp_q;       // read slot
  logic [1:0]   cnt_q;      // entries held

  // slot contents, written only on push
  always_ff @(posedge sys_clk) begin
    if (bif.push) begin
      mem_q[wp_q] <= bif.wdata;
    end
  end

  // pointers and fill count; flush overrides everything
  always_ff @(posedge sys_clk) begin
    if (!rst_n || bif.flush) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (bif.push) wp_q <= ~wp_q;
      if (bif.pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, bif.push} - {1'b0, bif.pop};
    end
  end

  assign bif.rdata = mem_q[rp_q];
  assign bif.full  = (cnt_q == 2'h2);
  assign bif.empty = (cnt_q == 2'h0);

  // flush always leaves nothing to read
  flush_empty_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bif.flush |=> bif.empty) else $error("buffer not empty after flush");
endmodule : urx_rxbuf

// File: hdl/urx_top.sv
// asynchronous serial receiver: oversampled start detection, majority vote,
// parity check, two-entry status buffer, Avalon-MM register slave
// assumes a 10 MHz system clock and an unsynchronised serial input pin
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module urx_top (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // avalon-mm slave
  input  wire logic [urx_pkg::URX_ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  // serial line
  input  wire logic                          serial_rx_pin,
  output logic                               rx_pin_override,
  // interrupt request
  output logic                               rx_complete_irq
);
  import urx_pkg::*;
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic        irq_en_q;    // rx_complete_irq_enable
  logic        rxen_q;      // receiver_enable
  logic        dspd_q;      // double_speed_select
  logic        par_en_q;    // parity_enable_bit
  logic        par_odd_q;   // parity_odd_select
  logic        stop_sel_q;  // stop_bit_count_select, no effect on reception
  logic [2:0]  size_q;      // character size code
  logic [11:0] baud_div_q;  // sample tick divisor

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic        req;    // any request present
  logic        ack_q;  // second cycle of a request
  logic        acc;    // request taken at this edge
  logic [31:0] rd_d;   // read mux
  logic [31:0] rd_q;

  // ----------------------------------------------------------------
  // receive datapath
  // ----------------------------------------------------------------
  logic             rx_m_q, rx_s_q;  // pin synchroniser
  logic [11:0]      baud_cnt_q;
  logic             tick;            // one sample period
  urx_state_t       state_q;
  logic [4:0]       cnt_q;           // sample number within a bit
  logic [3:0]       idx_q;           // bit position after start
  logic             s1_q, s2_q;      // first two centre samples
  logic [8:0]       shr_q;           // data shift register
  logic             pbit_q;          // received parity bit
  logic             vote;            // three-sample majority
  logic [4:0]       spb, v1;
  logic [3:0]       nbits;
  logic [8:0]       aligned;
  logic             start_acc, done, is_vote;
  logic [URX_E_W-1:0] pend_q;        // waiting character
  logic             pend_v_q;
  logic             dor_pend_q;      // loss not yet reported
  logic             lost;
  logic [URX_E_W-1:0] head;          // next readable entry, masked when empty
  logic             rxc;
  urx_buf_if #(.W(URX_E_W)) bif ();
  urx_rxbuf #(.W(URX_E_W)) u_buf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bif     (bif)
  );

  // ----------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------
  // every access waits exactly one cycle so read data can come from a flop
  assign req             = avs_read | avs_write;
  assign acc             = req & ack_q;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rd_q;
  // one-cycle wait generator
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end
  // read mux; status of the head entry comes out ahead of its data
  always_comb begin
    rd_d = 32'h0000_0000;  // unmapped reads return zero
    unique case (avs_address)
      URX_REG_STAT: begin
        rd_d[URX_ST_RXC]  = rxc;
        rd_d[URX_ST_FE]   = head[URX_E_FE];
        rd_d[URX_ST_DOR]  = head[URX_E_DOR];
        rd_d[URX_ST_PE]   = head[URX_E_PE];
        rd_d[URX_ST_DSPD] = dspd_q;
      end
      URX_REG_CTRL: begin
        rd_d[URX_CT_IRQ]  = irq_en_q;
        rd_d[URX_CT_RXEN] = rxen_q;
        rd_d[URX_CT_SZ2]  = size_q[2];
        rd_d[URX_CT_B9]   = head[8];
      end
      URX_REG_FMT: begin
        rd_d[URX_FM_PEN]  = par_en_q;
        rd_d[URX_FM_PODD] = par_odd_q;
        rd_d[URX_FM_STOP] = stop_sel_q;
        rd_d[URX_FM_SZ+:2] = size_q[1:0];
      end
      URX_REG_DATA: rd_d[7:0] = head[7:0];
      URX_REG_BAUD: rd_d[11:0] = baud_div_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end
  // read data captured in the wait cycle, stable at the accepting edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rd_q <= rd_d;
    end
  end
  // register writes; error flag positions have no storage at all
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_en_q   <= 1'b0;
      rxen_q     <= 1'b0;
      dspd_q     <= 1'b0;
      par_en_q   <= 1'b0;
      par_odd_q  <= 1'b0;
      stop_sel_q <= 1'b0;
      size_q     <= URX_SZ_RST;
      baud_div_q <= URX_BAUD_RST;
    end else if (acc && avs_write) begin
      unique case (avs_address)
        URX_REG_STAT: dspd_q <= avs_writedata[URX_ST_DSPD];
        URX_REG_CTRL: begin
          irq_en_q  <= avs_writedata[URX_CT_IRQ];
          rxen_q    <= avs_writedata[URX_CT_RXEN];
          size_q[2] <= avs_writedata[URX_CT_SZ2];
        end
        URX_REG_FMT: begin
          par_en_q    <= avs_writedata[URX_FM_PEN];
          par_odd_q   <= avs_writedata[URX_FM_PODD];
          stop_sel_q  <= avs_writedata[URX_FM_STOP];
          size_q[1:0] <= avs_writedata[URX_FM_SZ+:2];
        end
        URX_REG_BAUD: baud_div_q <= avs_writedata[11:0];
        default: ;  // data register and holes: writes ignored
      endcase
    end
  end

  // ----------------------------------------------------------------
  // buffer control and interrupt
  // ----------------------------------------------------------------
  assign rxc             = ~bif.empty;
  assign head            = bif.empty ? '0 : bif.rdata;
  assign rx_complete_irq = irq_en_q & rxc;
  assign rx_pin_override = rxen_q;
  assign bif.flush       = ~rxen_q;
  assign bif.pop         = acc & avs_read & (avs_address == URX_REG_DATA)
                         & rxc;
  assign bif.push        = pend_v_q & ~bif.full;
  assign bif.wdata       = {pend_q[URX_E_FE], dor_pend_q,
                            pend_q[URX_E_PE:0]};

  // ----------------------------------------------------------------
  // pin synchroniser and sample tick
  // ----------------------------------------------------------------
  // idle-high reset keeps a disabled line from looking like a start bit
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end else begin
      rx_m_q <= serial_rx_pin;
      rx_s_q <= rx_m_q;
    end
  end
  // divider makes the oversampling enable; stopped while disabled
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !rxen_q || tick) begin
      baud_cnt_q <= 12'h000;
    end else begin
      baud_cnt_q <= baud_cnt_q + 12'h001;
    end
  end
  assign tick = rxen_q & (baud_cnt_q == baud_div_q);

  // ----------------------------------------------------------------
  // frame decode helpers
  // ----------------------------------------------------------------
  assign spb     = dspd_q ? URX_SPB_DBL : URX_SPB_NORM;
  assign v1      = dspd_q ? URX_VOTE_DBL : URX_VOTE_NORM;
  assign is_vote = tick & (cnt_q == v1 + 5'h02);
  assign vote    = (s1_q & s2_q) | (s1_q & rx_s_q) | (s2_q & rx_s_q);
  // character size: codes 0..3 give 5..8 bits, code 7 gives nine
  always_comb begin
    unique case (size_q)
      3'h0:    nbits = 4'h5;
      3'h1:    nbits = 4'h6;
      3'h2:    nbits = 4'h7;
      3'h7:    nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  end
  // lsb arrives first, so shift right and drop the unused low part
  assign aligned   = shr_q >> (4'h9 - nbits);
  assign start_acc = tick & (state_q == URX_IDLE) & ~rx_s_q;
  // the stop bit follows data and optional parity; later stop bits ignored
  assign done      = is_vote & (state_q == URX_BITS)
                   & (idx_q == nbits + {3'h0, par_en_q});
  assign lost      = start_acc & pend_v_q & bif.full;

  // ----------------------------------------------------------------
  // receive state machine
  // ----------------------------------------------------------------
  // disable wins at once: any frame in progress is dropped
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !rxen_q) begin
      state_q <= URX_IDLE;
      cnt_q   <= 5'h00;
      idx_q   <= 4'h0;
    end else if (tick) begin
      unique case (state_q)
        URX_IDLE: begin
          if (!rx_s_q) begin
            state_q <= URX_START;
            cnt_q   <= 5'h02;  // this low sample is number one, next is two
          end
        end
        URX_START: begin
          cnt_q <= (cnt_q == spb) ? 5'h01 : cnt_q + 5'h01;
          if (is_vote) begin
            if (vote) begin
              state_q <= URX_IDLE;
            end else begin
              state_q <= URX_BITS;
              idx_q   <= 4'h0;
            end
          end
        end
        URX_BITS: begin
          cnt_q <= (cnt_q == spb) ? 5'h01 : cnt_q + 5'h01;
          if (is_vote) begin
            idx_q <= idx_q + 4'h1;
            if (done) begin
              state_q <= URX_IDLE;
            end
          end
        end
        default: state_q <= URX_IDLE;
      endcase
    end
  end
  // centre samples and bit capture
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      shr_q  <= 9'h000;
      pbit_q <= 1'b0;
    end else if (tick && state_q != URX_IDLE) begin
      if (cnt_q == v1) s1_q <= rx_s_q;
      if (cnt_q == v1 + 5'h01) s2_q <= rx_s_q;
      if (is_vote && state_q == URX_BITS) begin
        if (idx_q < nbits) begin
          shr_q <= {vote, shr_q[8:1]};
        end else if (idx_q == nbits && par_en_q) begin
          pbit_q <= vote;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // shift-register hold and overrun tracking
  // ----------------------------------------------------------------
  // a finished frame waits here until the buffer has room or a new start bit drops it
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !rxen_q) begin
      pend_v_q <= 1'b0;
      pend_q   <= '0;
    end else if (done) begin
      pend_v_q <= 1'b1;
      pend_q[8:0]       <= aligned;
      pend_q[URX_E_FE]  <= ~vote;
      pend_q[URX_E_DOR] <= 1'b0;
      pend_q[URX_E_PE]  <= par_en_q
                         & ((^aligned ^ par_odd_q) != pbit_q);
    end else if (lost || bif.push) begin
      pend_v_q <= 1'b0;
    end
  end
  // loss is remembered until carried by the next stored character
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !rxen_q) begin
      dor_pend_q <= 1'b0;
    end else if (lost) begin
      dor_pend_q <= 1'b1;
    end else if (bif.push) begin
      dor_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence start_edge_s;
    tick && state_q == URX_IDLE && !rx_s_q && rxen_q;
  endsequence
  sequence sync_s;
    state_q == URX_START && cnt_q == 5'h02;
  endsequence
  rxc_buffer_a: assert property (rxc == !bif.empty && (bif.empty -> !head[URX_E_PE]))
    else $error("complete flag disagrees with buffer");
  irq_follow_a: assert property (rxc && irq_en_q |-> rx_complete_irq ##1
    (rx_complete_irq || !rxc || !irq_en_q)) else $error("interrupt dropped");
  irq_no_err_a: assert property (rx_complete_irq |-> irq_en_q && rxc)
    else $error("interrupt without unread character");
  pop_last_a: assert property (bif.pop && !bif.full && !bif.push |=> !rxc)
    else $error("flag still high after last read");
  disable_flush_a: assert property (!rxen_q |-> !rx_pin_override ##1 (!rxc
    && state_q == URX_IDLE)) else $error("disable not immediate");
  start_sync_a: assert property (start_edge_s |=> sync_s)
    else $error("start not synchronised on first low sample");
  noise_drop_a: assert property (state_q == URX_START && is_vote && vote
    |=> state_q == URX_IDLE) else $error("noise start not rejected");
  frame_err_a: assert property (done |=> pend_q[URX_E_FE] == !$past(vote))
    else $error("frame error does not follow stop bit");
  parity_off_a: assert property (done && !par_en_q |=> !pend_q[URX_E_PE])
    else $error("parity error while checking off");
  overrun_mark_a: assert property (lost |=> dor_pend_q [*1] ##0 !pend_v_q)
    else $error("overrun not recorded");
endmodule : urx_top

// File: include/urx_buf_if.sv
// link between the receiver core and its two-entry character buffer
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface urx_buf_if #(parameter int W = 12);
  logic         push;   // write one entry
  logic         pop;    // drop the oldest entry
  logic         flush;  // empty the buffer at once
  logic [W-1:0] wdata;  // entry written
  logic [W-1:0] rdata;  // oldest entry
  logic         full;
  logic         empty;
  modport owner  (output push, pop, flush, wdata, input rdata, full, empty);
  modport buffer (input push, pop, flush, wdata, output rdata, full, empty);
endinterface : urx_buf_if

// File: include/urx_pkg.sv
// shared constants for the asynchronous serial receiver
// assumes a single 10 MHz system clock and a byte-addressed register view
package urx_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam int          URX_ADDR_W   = 5;
  localparam logic [4:0]  URX_REG_STAT = 5'h00;  // serial_status_reg_a
  localparam logic [4:0]  URX_REG_CTRL = 5'h04;  // serial_control_reg_b
  localparam logic [4:0]  URX_REG_FMT  = 5'h08;  // serial_control_reg_c
  localparam logic [4:0]  URX_REG_DATA = 5'h0C;  // serial_data_reg
  localparam logic [4:0]  URX_REG_BAUD = 5'h10;  // sample tick divisor
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int URX_ST_RXC  = 7;  // rx_complete_flag
  localparam int URX_ST_FE   = 4;  // frame_error_flag
  localparam int URX_ST_DOR  = 3;  // overrun_flag
  localparam int URX_ST_PE   = 2;  // parity_error_flag
  localparam int URX_ST_DSPD = 1;  // double_speed_select
  localparam int URX_CT_IRQ  = 7;  // rx_complete_irq_enable
  localparam int URX_CT_RXEN = 4;  // receiver_enable
  localparam int URX_CT_SZ2  = 2;  // character size, top bit
  localparam int URX_CT_B9   = 1;  // rx_ninth_bit
  localparam int URX_FM_PEN  = 5;  // parity_enable_bit
  localparam int URX_FM_PODD = 4;  // parity_odd_select
  localparam int URX_FM_STOP = 3;  // stop_bit_count_select
  localparam int URX_FM_SZ   = 1;  // character size, low two bits at [2:1]
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [11:0] URX_BAUD_RST = 12'h019;  // plain default divisor
  localparam logic [2:0]  URX_SZ_RST   = 3'h3;     // eight data bits
  localparam logic [4:0]  URX_SPB_NORM = 5'h10;    // samples per bit, normal
  localparam logic [4:0]  URX_SPB_DBL  = 5'h08;    // samples per bit, double
  localparam logic [4:0]  URX_VOTE_NORM = 5'h08;   // first centre sample
  localparam logic [4:0]  URX_VOTE_DBL  = 5'h04;
  // ----------------------------------------------------------------
  // buffer entry layout
  // ----------------------------------------------------------------
  localparam int URX_E_W   = 12;
  localparam int URX_E_PE  = 9;
  localparam int URX_E_DOR = 10;
  localparam int URX_E_FE  = 11;
  typedef enum logic [1:0] {URX_IDLE, URX_START, URX_BITS} urx_state_t;
endpackage : urx_pkg

// File: tb/tb.sv
// self-checking bench for the serial receiver
// assumes divisor 0, so one sample tick per system clock
`timescale 1ns/1ps
module tb;
  import urx_pkg::*;
  logic        sys_clk         = 1'b0;  // 10 MHz
  logic        rst_n           = 1'b0;
  logic [4:0]  avs_address     = 5'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        line;                    // from the transmitter model
  logic        rx_pin_override;
  logic        rx_complete_irq;
  logic [31:0] q;
  int          fails           = 0;
  int          checks_done     = 0;
  always #50 sys_clk = ~sys_clk;
  urx_top urx_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_rx_pin(line), .rx_pin_override(rx_pin_override),
    .rx_complete_irq(rx_complete_irq));
  urx_serial_src urx_serial_src_inst (.sys_clk(sys_clk), .line(line));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : chk
  // one bus transfer held until waitrequest is seen low at an edge
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    while (!ok) begin
      @(posedge sys_clk);
      ok = (avs_waitrequest === 1'b0);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);  // no re-raise in the release time step
  endtask : xfer
  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask : rd
  task automatic tx(input logic [9:0] b, input int nb, input logic stp, input int bl);
    urx_serial_src_inst.send(b, nb, stp, bl);
  endtask : tx
  task automatic t_basic();
    xfer(1'b1, URX_REG_CTRL, 32'h90);
    chk("override", 32'h1, {31'h0, rx_pin_override});
    tx(10'h0A5, 8, 1'b1, 16);
    chk("irq", 32'h1, {31'h0, rx_complete_irq});
    rd("status", URX_REG_STAT, 32'h80);
    rd("data", URX_REG_DATA, 32'hA5);
    rd("status", URX_REG_STAT, 32'h00);
    chk("irq", 32'h0, {31'h0, rx_complete_irq});
  endtask : t_basic
  task automatic t_frame();
    xfer(1'b1, URX_REG_CTRL, 32'h10);
    tx(10'h05A, 8, 1'b0, 16);
    chk("irq", 32'h0, {31'h0, rx_complete_irq});
    xfer(1'b1, URX_REG_STAT, 32'h1C);
    rd("status", URX_REG_STAT, 32'h90);
    rd("data", URX_REG_DATA, 32'h5A);
  endtask : t_frame
  task automatic t_parity();
    xfer(1'b1, URX_REG_FMT, 32'h26);
    tx(10'h1A5, 9, 1'b1, 16);
    rd("status", URX_REG_STAT, 32'h84);
    rd("data", URX_REG_DATA, 32'hA5);
    xfer(1'b1, URX_REG_FMT, 32'h36);
    tx(10'h1A5, 9, 1'b1, 16);
    rd("status", URX_REG_STAT, 32'h80);
    rd("data", URX_REG_DATA, 32'hA5);
    xfer(1'b1, URX_REG_FMT, 32'h06);
    xfer(1'b1, URX_REG_CTRL, 32'h14);
    tx(10'h1A5, 9, 1'b1, 16);
    rd("ninth", URX_REG_CTRL, 32'h16);
    rd("data", URX_REG_DATA, 32'hA5);
    xfer(1'b1, URX_REG_CTRL, 32'h10);
  endtask : t_parity
  task automatic t_overrun();
    for (int i = 1; i <= 4; i++) tx(10'(i * 'h11), 8, 1'b1, 16);
    rd("status", URX_REG_STAT, 32'h80);
    rd("data", URX_REG_DATA, 32'h11);
    rd("data", URX_REG_DATA, 32'h22);
    rd("status", URX_REG_STAT, 32'h88);
    rd("data", URX_REG_DATA, 32'h44);
    tx(10'h055, 8, 1'b1, 16);
    rd("status", URX_REG_STAT, 32'h80);
    rd("data", URX_REG_DATA, 32'h55);
  endtask : t_overrun
  task automatic t_misc();
    urx_serial_src_inst.glitch(3);
    rd("status", URX_REG_STAT, 32'h00);
    xfer(1'b1, URX_REG_STAT, 32'h02);
    tx(10'h0C3, 8, 1'b1, 8);
    rd("status", URX_REG_STAT, 32'h82);
    rd("data", URX_REG_DATA, 32'hC3);
    xfer(1'b1, URX_REG_STAT, 32'h00);
    xfer(1'b1, URX_REG_FMT, 32'h00);
    tx(10'h3FF, 5, 1'b1, 16);
    rd("data", URX_REG_DATA, 32'h1F);
    tx(10'h077, 5, 1'b1, 16);
    rd("status", URX_REG_STAT, 32'h80);
    xfer(1'b1, URX_REG_CTRL, 32'h00);
    rd("status", URX_REG_STAT, 32'h00);
    chk("override", 32'h0, {31'h0, rx_pin_override});
  endtask : t_misc
  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd("fmt", URX_REG_FMT, 32'h06);
    rd("baud", URX_REG_BAUD, 32'h019);
    rd("unmapped", 5'h14, 32'h0);
    xfer(1'b1, URX_REG_BAUD, 32'h0);
    t_basic();
    t_frame();
    t_parity();
    t_overrun();
    t_misc();
    final_report();
  end
endmodule : tb

// File: tb/urx_serial_src.sv
// remote serial transmitter model driving the receive line
// assumes the bench gives the bit length in system clock cycles
`timescale 1ns/1ps
module urx_serial_src (
  // clock
  input wire logic sys_clk,
  // serial line, idle high between frames
  output logic     line
);
  initial line = 1'b1;
  // one frame: start, nb bits lsb first, then one stop level
  task automatic send(input logic [9:0] bits, input int nb, input logic stp, input int bl);
    line <= 1'b0;
    repeat (bl) @(posedge sys_clk);
    for (int i = 0; i < nb; i++) begin
      line <= bits[i];
      repeat (bl) @(posedge sys_clk);
    end
    line <= stp;
    repeat (bl) @(posedge sys_clk);
    line <= 1'b1;
    // settle: synchroniser and push land before the bench looks
    repeat (12) @(posedge sys_clk);
  endtask : send
  // short low spike, too short to pass the start vote
  task automatic glitch(input int n);
    line <= 1'b0;
    repeat (n) @(posedge sys_clk);
    line <= 1'b1;
    repeat (40) @(posedge sys_clk);
  endtask : glitch
endmodule : urx_serial_src
